// ==== common/ibmm_defs.svh ====
/*
 * Constants of the multi-master two-wire bus monitor: register offsets,
 * field positions, reset values and timing counts.
 * Assumes a 125 MHz system clock and a 32-bit classic Wishbone slave port.
 */
// Operation
// - While asleep, slave address match or finished byte wakes processor if enabled.
// - Any reset disables the port and aborts the transfer in progress.
// - Reset or port disable clears both start-seen and stop-seen bits.
// - Multi-master mode interrupts on detected start and detected stop conditions.
// - Interrupt enabled while bus busy fires at the ending stop condition.
// - Sensed data-line level is compared with the level being driven.
// - Arbitration check is hardware; a mismatch sets the bus collision flag.
// - Check active in address, data, start, repeated start and acknowledge phases.
// - Slave collision while transmitting returns the slave to idle.
`ifndef IBMM_DEFS_SVH
`define IBMM_DEFS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define IBMM_ADR_CTRL     8'h00
`define IBMM_ADR_STATUS   8'h04
`define IBMM_ADR_ISTAT    8'h08
`define IBMM_ADR_ICLR     8'h0C
`define IBMM_ADR_IEN      8'h10

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define IBMM_CTRL_EN      0
`define IBMM_CTRL_MM      1
`define IBMM_CTRL_SCD     2
`define IBMM_CTRL_W       3
`define IBMM_IRQ_START    0
`define IBMM_IRQ_STOP     1
`define IBMM_IRQ_COLL     2
`define IBMM_IRQ_SLV      3
`define IBMM_IRQ_W        4

// ----------------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------------
`define IBMM_CTRL_RST     3'h0
`define IBMM_IEN_RST      4'h0
`define IBMM_CLK_NS       8
`define IBMM_SETTLE_NS    48
`define IBMM_SETTLE_CYC   ((`IBMM_SETTLE_NS + `IBMM_CLK_NS - 1) / `IBMM_CLK_NS)
`define IBMM_SETTLE_W     3

`endif

// ==== common/ibmm_pkg.sv ====
/*
 * Types of the multi-master two-wire bus monitor.
 * Assumes ibmm_defs.svh on the include path.
 */
`include "ibmm_defs.svh"

package ibmm_pkg;

	// ------------------------------------------------------------------------
	// Arbitration state
	// ------------------------------------------------------------------------
	typedef enum logic [2:0]
	{
		ARB_IDLE  = 3'h1,
		ARB_DRIVE = 3'h2,
		ARB_LOST  = 3'h4
	} ibmm_arb_t;

	// ------------------------------------------------------------------------
	// Whole state of the monitor
	// ------------------------------------------------------------------------
	typedef struct packed
	{
		logic [`IBMM_CTRL_W-1:0]   ctrl;
		logic [`IBMM_IRQ_W-1:0]    istat;
		logic [`IBMM_IRQ_W-1:0]    ien;
		logic                      start_seen;
		logic                      stop_seen;
		ibmm_arb_t                 arb;
		logic                      drive_low;
		logic [`IBMM_SETTLE_W-1:0] settle;
		logic                      scl_q;
		logic                      sda_q;
		logic                      slave_idle;
		logic                      wake;
		logic                      irq;
		logic                      ack;
		logic [31:0]               rdata;
	} ibmm_state_t;

endpackage

// ==== hdl/ibmm_sync.sv ====
/*
 * Three-stage synchroniser with agreement filter for asynchronous pins.
 * Assumes inputs from outside the clk_i domain; idle level is high.
 */
`timescale 1ns/1ps

module ibmm_sync
#(
	parameter int WIDTH = 2
)
(
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic [WIDTH-1:0] d_i,
	output logic      [WIDTH-1:0] q_o
);

	typedef struct packed
	{
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] q;
	} ibmm_sync_st_t;

	ibmm_sync_st_t s;
	ibmm_sync_st_t next_s;

	// ------------------------------------------------------------------------
	// Stage chain; output follows once stages two and three agree
	// ------------------------------------------------------------------------
	always_comb
	begin
		next_s = s;
		next_s.s1 = d_i;
		next_s.s2 = s.s1;
		next_s.s3 = s.s2;
		for (int i = 0; i < WIDTH; i++)
		begin
			if (s.s2[i] == s.s3[i])
			begin
				next_s.q[i] = s.s3[i];
			end
		end
		if (rst_i)
		begin
			next_s = {4*WIDTH{1'b1}};
		end
	end

	always_ff @(posedge clk_i)
	begin
		s <= next_s;
	end

	assign q_o = s.q;

endmodule

// ==== hdl/ibmm_monitor.sv ====
/*
 * Multi-master two-wire bus monitor: start/stop tracking, arbitration
 * check, sleep wake-up, interrupts and a classic Wishbone register slave.
 * Assumes an outside byte engine that reports its drive intent and slave
 * events, an open-drain data pad resolved outside, and clk_i at 125 MHz.
 */
// Implementation choices: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
`include "ibmm_defs.svh"

module ibmm_monitor
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [31:0] dat_i,
	input  wire logic [3:0]  sel_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	input  wire logic        scl_i,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe_o,
	input  wire logic        tx_active_i,
	input  wire logic        tx_sda_i,
	input  wire logic        slave_tx_i,
	input  wire logic        slave_addr_match_i,
	input  wire logic        slave_byte_done_i,
	input  wire logic        sleep_i,
	output logic             port_enable_o,
	output logic             xfer_abort_o,
	output logic             slave_idle_o,
	output logic             bus_free_o,
	output logic             wake_o,
	output logic             irq_o
);

	localparam logic [`IBMM_SETTLE_W-1:0] SETTLE = `IBMM_SETTLE_W'(`IBMM_SETTLE_CYC);

	ibmm_pkg::ibmm_state_t s;
	ibmm_pkg::ibmm_state_t next_s;

	logic                   scl_f;
	logic                   sda_f;
	logic                   en;
	logic                   mm_en;
	logic                   scd_en;
	logic                   start_ev;
	logic                   stop_ev;
	logic                   coll_hit;
	logic                   req;
	logic                   wr_now;
	logic [`IBMM_IRQ_W-1:0] set_v;
	logic [`IBMM_IRQ_W-1:0] clr_v;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	// ------------------------------------------------------------------------
	// Pin synchroniser
	// ------------------------------------------------------------------------
	ibmm_sync
	#(
		.WIDTH (2)
	)
	u_sync
	(
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   ({scl_i, sda_i}),
		.q_o   ({scl_f, sda_f})
	);

	// ------------------------------------------------------------------------
	// Event decode
	// ------------------------------------------------------------------------
	assign en       = s.ctrl[`IBMM_CTRL_EN];
	assign mm_en    = s.ctrl[`IBMM_CTRL_MM];
	assign scd_en   = s.ctrl[`IBMM_CTRL_SCD];
	assign start_ev = en & scl_f & s.scl_q & s.sda_q & ~sda_f;
	assign stop_ev  = en & scl_f & s.scl_q & ~s.sda_q & sda_f;
	assign req      = cyc_i & stb_i;
	assign wr_now   = req & s.ack & we_i & sel_i[0];

	// Released line sensed low while clock high, once our own edge settled
	assign coll_hit = en & (s.arb == ibmm_pkg::ARB_DRIVE) & tx_active_i
		& (s.settle == SETTLE) & ~s.drive_low & scl_f & ~sda_f
		& ((mm_en & ~slave_tx_i) | (scd_en & slave_tx_i));

	always_comb
	begin
		set_v = '0;
		set_v[`IBMM_IRQ_START] = start_ev & mm_en;
		set_v[`IBMM_IRQ_STOP]  = stop_ev & mm_en;
		set_v[`IBMM_IRQ_COLL]  = coll_hit;
		set_v[`IBMM_IRQ_SLV]   = en & (slave_addr_match_i | slave_byte_done_i);
		clr_v = '0;
		if (wr_now && adr_i == `IBMM_ADR_ICLR)
		begin
			clr_v = dat_i[`IBMM_IRQ_W-1:0];
		end
	end

	// ------------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------------
	always_comb
	begin
		next_s = s;
		next_s.scl_q = scl_f;
		next_s.sda_q = sda_f;

		// Bus state tracking
		if (start_ev)
		begin
			next_s.start_seen = 1'b1;
			next_s.stop_seen  = 1'b0;
		end
		if (stop_ev)
		begin
			next_s.stop_seen  = 1'b1;
			next_s.start_seen = 1'b0;
		end

		// Arbitration
		case (s.arb)
			ibmm_pkg::ARB_IDLE:
			begin
				if (en && tx_active_i)
				begin
					next_s.arb = ibmm_pkg::ARB_DRIVE;
				end
			end
			ibmm_pkg::ARB_DRIVE:
			begin
				if (coll_hit)
				begin
					next_s.arb = ibmm_pkg::ARB_LOST;
				end
				else if (!tx_active_i)
				begin
					next_s.arb = ibmm_pkg::ARB_IDLE;
				end
			end
			ibmm_pkg::ARB_LOST:
			begin
				if (stop_ev)
				begin
					next_s.arb = ibmm_pkg::ARB_IDLE;
				end
			end
			default:
			begin
				next_s.arb = ibmm_pkg::ARB_IDLE;
			end
		endcase
		next_s.drive_low = (next_s.arb == ibmm_pkg::ARB_DRIVE) & tx_active_i
			& ~tx_sda_i;
		if (next_s.drive_low != s.drive_low)
		begin
			next_s.settle = '0;
		end
		else if (s.settle != SETTLE)
		begin
			next_s.settle = s.settle + `IBMM_SETTLE_W'(1);
		end
		next_s.slave_idle = coll_hit & slave_tx_i;

		// Registers
		if (wr_now && adr_i == `IBMM_ADR_CTRL)
		begin
			next_s.ctrl = dat_i[`IBMM_CTRL_W-1:0];
		end
		if (wr_now && adr_i == `IBMM_ADR_IEN)
		begin
			next_s.ien = dat_i[`IBMM_IRQ_W-1:0];
		end
		// Set wins over clear
		next_s.istat = (s.istat & ~clr_v) | set_v;

		// Port disabled: bus state forgotten, transfer dropped
		if (!en)
		begin
			next_s.start_seen = 1'b0;
			next_s.stop_seen  = 1'b0;
			next_s.arb        = ibmm_pkg::ARB_IDLE;
			next_s.drive_low  = 1'b0;
		end

		// Wishbone answer, one cycle after the request
		next_s.ack = req & ~s.ack;
		if (req && !s.ack && !we_i)
		begin
			case (adr_i)
				`IBMM_ADR_CTRL:
				begin
					next_s.rdata = {29'h0, s.ctrl};
				end
				`IBMM_ADR_STATUS:
				begin
					next_s.rdata = {26'h0, sda_f, scl_f, s.arb == ibmm_pkg::ARB_LOST,
						bus_free_o, s.stop_seen, s.start_seen};
				end
				`IBMM_ADR_ISTAT:
				begin
					next_s.rdata = {28'h0, s.istat};
				end
				`IBMM_ADR_IEN:
				begin
					next_s.rdata = {28'h0, s.ien};
				end
				default:
				begin
					next_s.rdata = 32'h0;
				end
			endcase
		end

		// Interrupt and wake-up from the updated flags
		next_s.irq  = |(next_s.istat & next_s.ien);
		next_s.wake = sleep_i & next_s.istat[`IBMM_IRQ_SLV]
			& next_s.ien[`IBMM_IRQ_SLV];

		if (rst_i)
		begin
			next_s       = '0;
			next_s.arb   = ibmm_pkg::ARB_IDLE;
			next_s.ctrl  = `IBMM_CTRL_RST;
			next_s.ien   = `IBMM_IEN_RST;
			next_s.scl_q = 1'b1;
			next_s.sda_q = 1'b1;
		end
	end

	always_ff @(posedge clk_i)
	begin
		s <= next_s;
	end

	// ------------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------------
	assign dat_o         = s.rdata;
	assign ack_o         = s.ack;
	assign sda_o         = 1'b0;
	assign sda_oe_o      = s.drive_low;
	assign port_enable_o = en;
	assign xfer_abort_o  = ~en;
	assign slave_idle_o  = s.slave_idle;
	assign bus_free_o    = s.stop_seen | (~s.start_seen & ~s.stop_seen);
	assign wake_o        = s.wake;
	assign irq_o         = s.irq;

	// ------------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------------
	sequence seq_start;
		scl_f && sda_f ##1 scl_f && !sda_f;
	endsequence

	sequence seq_stop;
		scl_f && !sda_f ##1 scl_f && sda_f;
	endsequence

	AST_START_IRQ: assert property
		(en && mm_en ##0 seq_start |=> s.istat[`IBMM_IRQ_START])
		else $error("start condition did not set its flag");

	AST_STOP_IRQ: assert property
		(en && mm_en && s.ien[`IBMM_IRQ_STOP] && !rst_i ##0 seq_stop
			|=> s.istat[`IBMM_IRQ_STOP] && irq_o)
		else $error("stop condition raised no interrupt");

	AST_DIS_CLEAR: assert property
		(!en |=> !s.start_seen && !s.stop_seen && !sda_oe_o)
		else $error("disabled port kept start or stop seen");

	AST_COLL_FLAG: assert property
		(coll_hit |=> s.istat[`IBMM_IRQ_COLL] && s.arb == ibmm_pkg::ARB_LOST)
		else $error("collision not flagged");

	AST_RELEASE: assert property
		(coll_hit |=> !sda_oe_o throughout (s.arb == ibmm_pkg::ARB_LOST)[*2])
		else $error("data line still driven after arbitration loss");

	AST_COMPARE: assert property
		(s.arb == ibmm_pkg::ARB_DRIVE && tx_active_i && mm_en && !slave_tx_i
			&& s.settle == SETTLE && !s.drive_low && scl_f && !sda_f
			|=> s.arb == ibmm_pkg::ARB_LOST)
		else $error("released line sensed low was not caught");

	AST_SLAVE_IDLE: assert property
		(coll_hit && slave_tx_i |=> slave_idle_o ##1 !slave_idle_o)
		else $error("slave collision did not return slave to idle");

	AST_WAKE: assert property
		(en && sleep_i && slave_addr_match_i && s.ien[`IBMM_IRQ_SLV] |=> wake_o)
		else $error("slave event in sleep did not wake");

	AST_ACK: assert property
		(req && !ack_o |=> ack_o ##1 !ack_o)
		else $error("bus answer not one cycle after request");

	AST_RESET: assert property
		(@(posedge clk_i) disable iff (1'b0) rst_i |=> !port_enable_o && !sda_oe_o && !irq_o)
		else $error("reset left port enabled or driving");

endmodule

// ==== tb/ibmm_peer.sv ====
/*
 * Behavioural second master sharing the two-wire bus with the monitor.
 * Assumes pull-ups on both lines and a 125 MHz clk_i for its pacing.
 */
`timescale 1ns/1ps

module ibmm_peer
(
	input  wire logic clk_i,
	output logic      scl_low_o,
	output logic      sda_low_o
);
	initial
	begin
		scl_low_o = 1'b0;
		sda_low_o = 1'b0;
	end

	// Half of a 64 ns link period
	task automatic half;
		repeat (4) @(posedge clk_i);
	endtask

	// Called only with the bus free; the bench checks bus_free_o first in t_start_stop and t_arb only
	task automatic start_cond;
		sda_low_o <= 1'b1;
		half();
		half();
		scl_low_o <= 1'b1;
		half();
	endtask

	task automatic stop_cond;
		sda_low_o <= 1'b1;
		half();
		scl_low_o <= 1'b0;
		half();
		sda_low_o <= 1'b0;
		half();
	endtask
endmodule

// ==== tb/tb_top.sv ====
/*
 * Self-checking bench of the multi-master bus monitor.
 * Assumes the peer model on the far side and open-drain lines with pull-ups.
 */
`timescale 1ns/1ps
`include "ibmm_defs.svh"

module tb_top;
	logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
	logic [7:0]  adr_i = 8'h0;
	logic [31:0] dat_i = 32'h0, dat_o;
	logic [3:0]  sel_i = 4'hF;
	logic        tx_active_i = 1'b0, tx_sda_i = 1'b1, slave_tx_i = 1'b0, sleep_i = 1'b0;
	logic        slave_addr_match_i = 1'b0, slave_byte_done_i = 1'b0;
	logic        ack_o, scl_i, sda_i, sda_o, sda_oe_o, port_enable_o, xfer_abort_o;
	logic        slave_idle_o, bus_free_o, wake_o, irq_o, scl_low, sda_low;
	int          failures = 0;
	int          total_checks = 0;

	assign scl_i = ~scl_low;
	assign sda_i = ~sda_low & (sda_oe_o ? sda_o : 1'b1);

	ibmm_monitor i_dut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_i, .sel_i,
		.dat_o, .ack_o, .scl_i, .sda_i, .sda_o, .sda_oe_o, .tx_active_i, .tx_sda_i,
		.slave_tx_i, .slave_addr_match_i, .slave_byte_done_i, .sleep_i, .port_enable_o,
		.xfer_abort_o, .slave_idle_o, .bus_free_o, .wake_o, .irq_o);
	ibmm_peer i_peer (.clk_i, .scl_low_o(scl_low), .sda_low_o(sda_low));

	always #4 clk_i = ~clk_i;

	// ------------------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("[FAIL] t=%0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (ack_o !== 1'b1);
		q = dat_o;
		chk(n, 32'h2);
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] q;
		wb(1'b0, a, 32'h0, q);
		chk(q & m, e);
	endtask

	task automatic await_irq;
		for (int n = 0; n < 40 && irq_o !== 1'b1; n++) @(posedge clk_i);
	endtask

	// ------------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------------
	task automatic t_reset_vals;
		chk({port_enable_o, xfer_abort_o}, 32'h1);
		chk({irq_o, wake_o, sda_oe_o, slave_idle_o, bus_free_o}, 32'h1);
		rchk(`IBMM_ADR_CTRL, 32'hFFFFFFFF, 32'h0);
		rchk(`IBMM_ADR_IEN, 32'hFFFFFFFF, 32'h0);
		rchk(`IBMM_ADR_STATUS, 32'h3F, 32'h34);
		rchk(8'h20, 32'hFFFFFFFF, 32'h0);
		rchk(`IBMM_ADR_ICLR, 32'hFFFFFFFF, 32'h0);
	endtask

	task automatic t_start_stop;
		wr(`IBMM_ADR_CTRL, 32'h3);
		chk(bus_free_o, 32'h1);
		i_peer.start_cond();
		repeat (8) @(posedge clk_i);
		rchk(`IBMM_ADR_ISTAT, 32'hF, 32'h1);
		rchk(`IBMM_ADR_STATUS, 32'h7, 32'h1);
		chk({bus_free_o, irq_o}, 32'h0);
		wr(`IBMM_ADR_ICLR, 32'h1);
		wr(`IBMM_ADR_IEN, 32'h2);
		chk(irq_o, 32'h0);
		i_peer.stop_cond();
		await_irq();
		chk(irq_o, 32'h1);
		rchk(`IBMM_ADR_ISTAT, 32'hF, 32'h2);
		rchk(`IBMM_ADR_STATUS, 32'h7, 32'h6);
		wr(`IBMM_ADR_ICLR, 32'h2);
		repeat (2) @(posedge clk_i);
		chk(irq_o, 32'h0);
	endtask

	task automatic t_arb;
		wr(`IBMM_ADR_IEN, 32'h4);
		tx_active_i <= 1'b1;
		tx_sda_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		chk(sda_oe_o, 32'h1);
		chk(sda_o, 32'h0);
		tx_sda_i <= 1'b1;
		repeat (12) @(posedge clk_i);
		chk({sda_oe_o, bus_free_o}, 32'h1);
		i_peer.start_cond();
		await_irq();
		chk(irq_o, 32'h1);
		rchk(`IBMM_ADR_ISTAT, 32'h4, 32'h4);
		tx_sda_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		chk(sda_oe_o, 32'h0);
		rchk(`IBMM_ADR_STATUS, 32'h8, 32'h8);
		tx_active_i <= 1'b0;
		i_peer.stop_cond();
		wr(`IBMM_ADR_ICLR, 32'hF);
		chk({bus_free_o, irq_o}, 32'h2);
		tx_active_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk(sda_oe_o, 32'h1);
		tx_active_i <= 1'b0;
		tx_sda_i <= 1'b1;
		repeat (12) @(posedge clk_i);
		wr(`IBMM_ADR_ICLR, 32'hF);
	endtask

	task automatic t_slave(input logic scd);
		logic seen;
		seen = 1'b0;
		wr(`IBMM_ADR_CTRL, {29'h0, scd, 2'h3});
		slave_tx_i <= 1'b1;
		tx_active_i <= 1'b1;
		repeat (10) @(posedge clk_i);
		fork
			i_peer.start_cond();
			for (int n = 0; n < 40; n++)
			begin
				@(posedge clk_i);
				seen = seen | (slave_idle_o === 1'b1);
			end
		join
		chk(seen, {31'h0, scd});
		tx_active_i <= 1'b0;
		slave_tx_i <= 1'b0;
		i_peer.stop_cond();
		wr(`IBMM_ADR_ICLR, 32'hF);
	endtask

	task automatic t_wake;
		wr(`IBMM_ADR_CTRL, 32'h1);
		wr(`IBMM_ADR_IEN, 32'h8);
		sleep_i <= 1'b1;
		slave_addr_match_i <= 1'b1;
		@(posedge clk_i);
		slave_addr_match_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		chk(wake_o, 32'h1);
		wr(`IBMM_ADR_IEN, 32'h0);
		wr(`IBMM_ADR_ICLR, 32'h8);
		slave_byte_done_i <= 1'b1;
		@(posedge clk_i);
		slave_byte_done_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		chk(wake_o, 32'h0);
		wr(`IBMM_ADR_IEN, 32'h8);
		repeat (3) @(posedge clk_i);
		chk(wake_o, 32'h1);
		sleep_i <= 1'b0;
		wr(`IBMM_ADR_ICLR, 32'hF);
	endtask

	task automatic t_disable;
		wr(`IBMM_ADR_CTRL, 32'h3);
		i_peer.start_cond();
		repeat (8) @(posedge clk_i);
		rchk(`IBMM_ADR_STATUS, 32'h3, 32'h1);
		wr(`IBMM_ADR_CTRL, 32'h0);
		rchk(`IBMM_ADR_STATUS, 32'h7, 32'h4);
		chk({port_enable_o, xfer_abort_o}, 32'h1);
		i_peer.stop_cond();
		wr(`IBMM_ADR_CTRL, 32'h3);
		i_peer.start_cond();
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk({port_enable_o, xfer_abort_o, bus_free_o}, 32'h3);
		rchk(`IBMM_ADR_CTRL, 32'h7, 32'h0);
		rchk(`IBMM_ADR_STATUS, 32'h3, 32'h0);
		i_peer.stop_cond();
	endtask

	task automatic conclude;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial
	begin
		repeat (6) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_reset_vals();
		t_start_stop();
		t_arb();
		t_slave(1'b0);
		t_slave(1'b1);
		t_wake();
		t_disable();
		conclude();
	end

	initial
	begin
		repeat (20000) @(posedge clk_i);
		failures++;
		conclude();
	end
endmodule
